// ===== rtl/pif_flags.sv
// peripheral interrupt flag register with an avalon-mm slave port
// assumes event pulses and buffer levels come from logic on i_clk
//
// The Avalon-MM slave port was left to the implementer.
`timescale 1ns/10ps
module pif_flags
(
	input  wire logic        i_clk,
	input  wire logic        i_resetn,
	input  wire logic [7:0]  i_address,
	input  wire logic        i_read,
	input  wire logic        i_write,
	input  wire logic [31:0] i_writedata,
	input  wire logic [3:0]  i_byteenable,
	output logic [31:0]      o_readdata,
	output logic             o_waitrequest,
	input  wire logic        i_eeprom_write_done,
	input  wire logic        i_comparator_change,
	input  wire logic        i_rx_buffer_full,
	input  wire logic        i_tx_buffer_empty,
	input  wire logic        i_capture_compare_event,
	input  wire logic        i_timer2_match,
	input  wire logic        i_timer1_overflow,
	output logic [7:0]       o_peripheral_irq_flags
);
	pif_pkg::pif_state_t state;
	pif_pkg::pif_state_t next_state;
	logic [7:0] sticky;
	logic       rx_flag;
	logic       tx_flag;

	wire logic       req      = i_read | i_write;
	wire logic       hit      = (i_address == pif_pkg::FLAGS_OFFSET);
	// writes land in the wait cycle so the acking edge sees the result once
	wire logic       wr_take  = (state == pif_pkg::PIF_IDLE) & i_write & hit & i_byteenable[0];
	wire logic [7:0] events;
	wire logic [7:0] keep;
	wire logic [7:0] next_sticky;
	wire logic [7:0] flags_view;

	// one decode of the visible byte, shared by the read port and the flag output
	function automatic logic [7:0] pif_view
	(
		input logic [7:0] s,
		input logic       rx,
		input logic       tx
	);
		return {s[7:6], rx, tx, 1'b0, s[2:0]};
	endfunction

	assign events = {i_eeprom_write_done, i_comparator_change, 3'b000,
		i_capture_compare_event, i_timer2_match, i_timer1_overflow} & pif_pkg::STICKY_MASK;
	// software may only clear sticky bits; writing one does not set them
	assign keep = wr_take ? (i_writedata[7:0] | ~pif_pkg::STICKY_MASK) : 8'hff;
	// set wins over a clear in the same cycle
	assign next_sticky = (sticky & keep & pif_pkg::STICKY_MASK) | events;
	// one byte, bit 3 zero; read port and flag output see the same next value
	assign flags_view = pif_view(next_sticky, i_rx_buffer_full, i_tx_buffer_empty);
	assign next_state = (state == pif_pkg::PIF_IDLE && req) ? pif_pkg::PIF_ACK : pif_pkg::PIF_IDLE;

	always_ff @(posedge i_clk or negedge i_resetn)
	begin
		if (!i_resetn)
			sticky <= pif_pkg::FLAGS_RESET;
		else
			sticky <= next_sticky;
	end

	always_ff @(posedge i_clk or negedge i_resetn)
	begin
		if (!i_resetn)
		begin
			rx_flag <= 1'b0;
			tx_flag <= 1'b0;
		end
		else
		begin
			rx_flag <= i_rx_buffer_full;
			tx_flag <= i_tx_buffer_empty;
		end
	end

	always_ff @(posedge i_clk or negedge i_resetn)
	begin
		if (!i_resetn)
		begin
			state         <= pif_pkg::PIF_IDLE;
			o_waitrequest <= 1'b1;
			o_readdata    <= pif_pkg::UNMAPPED_READ;
		end
		else
		begin
			state         <= next_state;
			o_waitrequest <= !(next_state == pif_pkg::PIF_ACK);
			if (state == pif_pkg::PIF_IDLE && i_read)
				o_readdata <= hit ? {24'h000000, flags_view} : pif_pkg::UNMAPPED_READ;
		end
	end

	always_ff @(posedge i_clk or negedge i_resetn)
	begin
		if (!i_resetn)
			o_peripheral_irq_flags <= pif_pkg::FLAGS_RESET;
		else
			o_peripheral_irq_flags <= flags_view;
	end

	event_sets_a: assert property (@(posedge i_clk) disable iff (!i_resetn)
		i_timer1_overflow |=> o_peripheral_irq_flags[pif_pkg::BIT_TMR1])
		else $error("timer1 overflow did not set its flag");
	cmp_flag_a: assert property (@(posedge i_clk) disable iff (!i_resetn)
		i_comparator_change |=> o_peripheral_irq_flags[pif_pkg::BIT_CMP])
		else $error("comparator change did not set bit 6");
	rx_follow_a: assert property (@(posedge i_clk) disable iff (!i_resetn)
		o_peripheral_irq_flags[pif_pkg::BIT_RX] == $past(i_rx_buffer_full))
		else $error("receive flag does not follow buffer");
	rx_empty_a: assert property (@(posedge i_clk) disable iff (!i_resetn)
		!i_rx_buffer_full ##1 !i_rx_buffer_full |=> !o_peripheral_irq_flags[pif_pkg::BIT_RX])
		else $error("receive flag high with empty buffer");
	tx_follow_a: assert property (@(posedge i_clk) disable iff (!i_resetn)
		o_peripheral_irq_flags[pif_pkg::BIT_TX] == $past(i_tx_buffer_empty))
		else $error("transmit flag does not follow buffer");
	ccp_hold_a: assert property (@(posedge i_clk) disable iff (!i_resetn)
		o_peripheral_irq_flags[pif_pkg::BIT_CCP] && !wr_take |=> o_peripheral_irq_flags[pif_pkg::BIT_CCP])
		else $error("capture flag dropped without a clear");
	unused_zero_a: assert property (@(posedge i_clk) disable iff (!i_resetn)
		!o_peripheral_irq_flags[pif_pkg::BIT_UNUSED] && !o_readdata[pif_pkg::BIT_UNUSED])
		else $error("bit 3 is not zero");
	clear_flag_a: assert property (@(posedge i_clk) disable iff (!i_resetn)
		wr_take && !i_writedata[pif_pkg::BIT_EEPROM] && !i_eeprom_write_done
		|=> !o_peripheral_irq_flags[pif_pkg::BIT_EEPROM])
		else $error("eeprom flag not cleared by write");
	// bus answers in one wait cycle
	bus_answer_a: assert property (@(posedge i_clk) disable iff (!i_resetn)
		(state == pif_pkg::PIF_IDLE) && req |=> !o_waitrequest ##1 o_waitrequest)
		else $error("bus answer not one cycle after request");
	read_flags_a: assert property (@(posedge i_clk) disable iff (!i_resetn)
		(state == pif_pkg::PIF_IDLE) && i_read && hit |=> o_readdata[7:0] == o_peripheral_irq_flags)
		else $error("read data differs from flags");

	eeprom_set_a: assert property (@(posedge i_clk) disable iff (!i_resetn)
		i_eeprom_write_done
		|=> o_peripheral_irq_flags[pif_pkg::BIT_EEPROM])
		else $error("eeprom completion did not set its flag");

	ccp_set_a: assert property (@(posedge i_clk) disable iff (!i_resetn)
		i_capture_compare_event
		|=> o_peripheral_irq_flags[pif_pkg::BIT_CCP])
		else $error("capture event did not set its flag");

	tmr2_set_a: assert property (@(posedge i_clk) disable iff (!i_resetn)
		i_timer2_match
		|=> o_peripheral_irq_flags[pif_pkg::BIT_TMR2])
		else $error("timer2 match did not set its flag");

	cmp_clear_a: assert property (@(posedge i_clk) disable iff (!i_resetn)
		wr_take && !i_writedata[pif_pkg::BIT_CMP] && !i_comparator_change
		|=> !o_peripheral_irq_flags[pif_pkg::BIT_CMP])
		else $error("comparator flag not cleared by write");

	ccp_clear_a: assert property (@(posedge i_clk) disable iff (!i_resetn)
		wr_take && !i_writedata[pif_pkg::BIT_CCP] && !i_capture_compare_event
		|=> !o_peripheral_irq_flags[pif_pkg::BIT_CCP])
		else $error("capture flag not cleared by write");

	tmr2_clear_a: assert property (@(posedge i_clk) disable iff (!i_resetn)
		wr_take && !i_writedata[pif_pkg::BIT_TMR2] && !i_timer2_match
		|=> !o_peripheral_irq_flags[pif_pkg::BIT_TMR2])
		else $error("timer2 flag not cleared by write");

	tmr1_clear_a: assert property (@(posedge i_clk) disable iff (!i_resetn)
		wr_take && !i_writedata[pif_pkg::BIT_TMR1] && !i_timer1_overflow
		|=> !o_peripheral_irq_flags[pif_pkg::BIT_TMR1])
		else $error("timer1 flag not cleared by write");

	eeprom_hold_a: assert property (@(posedge i_clk) disable iff (!i_resetn)
		o_peripheral_irq_flags[pif_pkg::BIT_EEPROM] && !wr_take
		|=> o_peripheral_irq_flags[pif_pkg::BIT_EEPROM])
		else $error("eeprom flag dropped without a clear");

	cmp_hold_a: assert property (@(posedge i_clk) disable iff (!i_resetn)
		o_peripheral_irq_flags[pif_pkg::BIT_CMP] && !wr_take
		|=> o_peripheral_irq_flags[pif_pkg::BIT_CMP])
		else $error("comparator flag dropped without a clear");

	tmr2_hold_a: assert property (@(posedge i_clk) disable iff (!i_resetn)
		o_peripheral_irq_flags[pif_pkg::BIT_TMR2] && !wr_take
		|=> o_peripheral_irq_flags[pif_pkg::BIT_TMR2])
		else $error("timer2 flag dropped without a clear");

	tmr1_hold_a: assert property (@(posedge i_clk) disable iff (!i_resetn)
		o_peripheral_irq_flags[pif_pkg::BIT_TMR1] && !wr_take
		|=> o_peripheral_irq_flags[pif_pkg::BIT_TMR1])
		else $error("timer1 flag dropped without a clear");

	// no event keeps clear flags clear
	sticky_quiet_a: assert property (@(posedge i_clk) disable iff (!i_resetn)
		((o_peripheral_irq_flags & pif_pkg::STICKY_MASK) == 8'h00) && (events == 8'h00)
		|=> ((o_peripheral_irq_flags & pif_pkg::STICKY_MASK) == 8'h00))
		else $error("sticky flag rose without an event");

	// writing one leaves a flag set
	write_one_keeps_a: assert property (@(posedge i_clk) disable iff (!i_resetn)
		wr_take && i_writedata[pif_pkg::BIT_TMR1] && o_peripheral_irq_flags[pif_pkg::BIT_TMR1]
		|=> o_peripheral_irq_flags[pif_pkg::BIT_TMR1])
		else $error("writing one cleared a flag");

	// lane 0 off ignores the write
	lane_off_a: assert property (@(posedge i_clk) disable iff (!i_resetn)
		(state == pif_pkg::PIF_IDLE) && i_write && hit && !i_byteenable[0] && o_peripheral_irq_flags[pif_pkg::BIT_TMR2]
		|=> o_peripheral_irq_flags[pif_pkg::BIT_TMR2])
		else $error("write without lane 0 changed a flag");

	unmapped_write_a: assert property (@(posedge i_clk) disable iff (!i_resetn)
		(state == pif_pkg::PIF_IDLE) && i_write && !hit && o_peripheral_irq_flags[pif_pkg::BIT_EEPROM]
		|=> o_peripheral_irq_flags[pif_pkg::BIT_EEPROM])
		else $error("unmapped write changed a flag");

	unmapped_read_a: assert property (@(posedge i_clk) disable iff (!i_resetn)
		(state == pif_pkg::PIF_IDLE) && i_read && !hit
		|=> o_readdata == pif_pkg::UNMAPPED_READ)
		else $error("unmapped read returned data");

	read_upper_a: assert property (@(posedge i_clk) disable iff (!i_resetn)
		o_readdata[31:8] == 24'h000000)
		else $error("upper read lanes not zero");

	rx_readonly_a: assert property (@(posedge i_clk) disable iff (!i_resetn)
		wr_take && i_writedata[pif_pkg::BIT_RX] && !i_rx_buffer_full
		|=> !o_peripheral_irq_flags[pif_pkg::BIT_RX])
		else $error("write changed the receive flag");

	tx_readonly_a: assert property (@(posedge i_clk) disable iff (!i_resetn)
		wr_take && !i_writedata[pif_pkg::BIT_TX] && i_tx_buffer_empty
		|=> o_peripheral_irq_flags[pif_pkg::BIT_TX])
		else $error("write changed the transmit flag");

	read_stands_a: assert property (@(posedge i_clk) disable iff (!i_resetn)
		!((state == pif_pkg::PIF_IDLE) && i_read)
		|=> $stable(o_readdata))
		else $error("read data changed without a read");

	// no request keeps the bus waiting
	idle_wait_a: assert property (@(posedge i_clk) disable iff (!i_resetn)
		(state == pif_pkg::PIF_IDLE) && !req
		|=> o_waitrequest)
		else $error("acknowledge without a request");

	// acknowledge only in the ack state
	ack_state_a: assert property (@(posedge i_clk) disable iff (!i_resetn)
		!o_waitrequest == (state == pif_pkg::PIF_ACK))
		else $error("waitrequest and state disagree");

	// read sees an event of its own cycle
	read_event_a: assert property (@(posedge i_clk) disable iff (!i_resetn)
		(state == pif_pkg::PIF_IDLE) && i_read && hit && i_timer2_match
		|=> o_readdata[pif_pkg::BIT_TMR2])
		else $error("read missed a same-cycle event");

	read_rx_a: assert property (@(posedge i_clk) disable iff (!i_resetn)
		(state == pif_pkg::PIF_IDLE) && i_read && hit
		|=> o_readdata[pif_pkg::BIT_RX] == $past(i_rx_buffer_full))
		else $error("read receive bit differs from buffer");

	// level copies match the flag byte
	level_copy_a: assert property (@(posedge i_clk) disable iff (!i_resetn)
		(rx_flag == o_peripheral_irq_flags[pif_pkg::BIT_RX]) && (tx_flag == o_peripheral_irq_flags[pif_pkg::BIT_TX]))
		else $error("buffer level copies disagree with flag byte");

	cover_read_c:  cover property (@(posedge i_clk) disable iff (!i_resetn) i_read && hit && !o_waitrequest);
	cover_clear_c: cover property (@(posedge i_clk) disable iff (!i_resetn) wr_take && (sticky != 8'h00));
	cover_race_c:  cover property (@(posedge i_clk) disable iff (!i_resetn) wr_take && i_timer2_match);
	cover_rx_c:    cover property (@(posedge i_clk) disable iff (!i_resetn) $fell(rx_flag));
endmodule

// ===== rtl/pif_pkg.sv
// constants for the peripheral interrupt flag register block
// assumes a 100 MHz core clock and an avalon-mm register slave
// Notes on behaviour
// - flags in one 8-bit register, offset 0ch
// - flags set regardless of enable bits
// - comparator change sets bit 6
// - receive flag follows buffer full, read-only
// - receive flag low when buffer empty
// - transmit flag follows buffer state, read-only
package pif_pkg;
	localparam logic [7:0] FLAGS_OFFSET = 8'h0c;
	localparam logic [7:0] FLAGS_RESET  = 8'h00;
	localparam int         BIT_EEPROM   = 7;
	localparam int         BIT_CMP      = 6;
	localparam int         BIT_RX       = 5;
	localparam int         BIT_TX       = 4;
	localparam int         BIT_UNUSED   = 3;
	localparam int         BIT_CCP      = 2;
	localparam int         BIT_TMR2     = 1;
	localparam int         BIT_TMR1     = 0;
	// bits that software may clear by writing zero
	localparam logic [7:0] STICKY_MASK  = 8'h87 | 8'h40;
	localparam logic [31:0] UNMAPPED_READ = 32'h0000_0000;
	typedef enum logic [1:0]
	{
		PIF_IDLE = 2'b00,
		PIF_ACK  = 2'b01
	} pif_state_t;
endpackage

// ===== tb/pif_periph.sv
// peripheral side model: event pulses and buffer levels
// assumes commands change just after a rising edge of i_clk
`timescale 1ns/10ps
module pif_periph
(
	input  wire logic       i_clk,
	input  wire logic [7:0] i_cmd,
	output logic [7:0]      o_evt
);
	always_ff @(posedge i_clk)
		o_evt <= i_cmd;
endmodule

// ===== tb/tb.sv
// self-checking bench for the flag register block
// assumes pif_flags and pif_periph on one 100 MHz clock
`timescale 1ns/10ps
module tb;
	logic        i_clk, i_resetn, rd, wr, wt;
	logic [7:0]  adr, c, ev, st, w, a, fl;
	logic [31:0] wd, q, rdat;
	logic [3:0]  be, b;
	int          miscompares, samples_checked;
	bit          hung;
	pif_periph i_per(.i_clk(i_clk), .i_cmd(c), .o_evt(ev));
	pif_flags i_dut(.i_clk(i_clk), .i_resetn(i_resetn), .i_address(adr), .i_read(rd), .i_write(wr),
		.i_writedata(wd), .i_byteenable(be), .o_readdata(rdat), .o_waitrequest(wt),
		.i_eeprom_write_done(ev[7]), .i_comparator_change(ev[6]), .i_rx_buffer_full(ev[5]),
		.i_tx_buffer_empty(ev[4]), .i_capture_compare_event(ev[2]), .i_timer2_match(ev[1]),
		.i_timer1_overflow(ev[0]), .o_peripheral_irq_flags(fl));
	task print_verdict;
		$display("checked %0d mismatches %0d", samples_checked, miscompares);
		if (miscompares == 0 && samples_checked > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask
	task chk(input logic [31:0] g, input logic [31:0] e);
		samples_checked++;
		if (g !== e)
		begin
			miscompares++;
			$display("MISMATCH %0t got %h exp %h", $time, g, e);
		end
	endtask
	// one avalon transfer, held until waitrequest is seen low
	task automatic bus(input logic w_, input logic [7:0] ad, input logic [7:0] d, input logic [3:0] bb);
		int n;
		rd <= !w_; wr <= w_; adr <= ad; wd <= {24'h0, d}; be <= bb; n = 0;
		do begin @(posedge i_clk); n++; end while (wt !== 1'b0 && n < 20);
		if (wt !== 1'b0)
		begin
			hung = 1'b1;
			chk(1, 0);
		end
		q = rdat; rd <= 1'b0; wr <= 1'b0;
		@(posedge i_clk);
	endtask
	// sticky bits from st, buffer levels straight from the command
	function logic [7:0] fexp(input logic [7:0] s, input logic [7:0] cc);
		return (s & 8'hc7) | (cc & 8'h30);
	endfunction
	initial
	begin
		i_clk = 1'b0;
		forever #5 i_clk = ~i_clk;
	end
	initial
	begin
		i_resetn = 1'b0; rd = 1'b0; wr = 1'b0; adr = 8'h00; wd = 32'h0; be = 4'h0; c = 8'h00; st = 8'h00;
		void'($urandom(10261));
		repeat (10) @(posedge i_clk);
		i_resetn <= 1'b1;
		@(posedge i_clk);
		chk(fl, 8'h00);
		for (int i = 0; i < 40; i++)
		begin
			if (hung)
				break;
			w = 8'($urandom); a = (i % 4 == 3) ? 8'($urandom) : 8'h0c; b = 4'($urandom);
			c <= (i == 0) ? 8'hff : (i == 1) ? 8'h00 : 8'($urandom);
			@(posedge i_clk);
			c <= c & 8'h30;
			st = st | (c & 8'hc7);
			repeat (3) @(posedge i_clk);
			chk(fl, fexp(st, c));
			bus(1'b0, 8'h0c, 8'h00, 4'hf);
			chk(q, {24'h0, fexp(st, c)});
			bus(1'b1, a, w, b);
			// a write to 0ch with lane 0 on clears the sticky bits written as zero
			if (a == 8'h0c && b[0])
				st = st & w;
			chk(fl, fexp(st, c));
			bus(1'b0, a, 8'h00, 4'hf);
			chk(q, (a == 8'h0c) ? {24'h0, fexp(st, c)} : 32'h0);
			$display("test %0d done", i);
		end
		print_verdict;
	end
endmodule
